// ### hdl/gam_pin_mux.sv
// pin multiplexer and direction control for the general purpose pins
//
// Overview of operation
// - one input pin, ten bidirectional pins
// - direction from direction and alternate bits
// - all pins inputs during reset
// - pins stay inputs until software configures
// - alternate select beats direction bit except on receive, bit zero and secondary data out
// - direction zero drives, one is input
// - alternate follows function; receive keeps direction
// - bits one-seven: uart, interrupts, timers, pwm
// - interrupts pass only when alternate set
// - bit zero always general purpose
// - data bits map to pins in order
// - route 01 gives spi, else timer c
// - no chip select from spi lines
// - radio route keeps selects internal
// - data, direction ff; alternate 00 at reset
`timescale 1ns/10ps
`default_nettype none
module gam_pin_mux (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // special function register port
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // primary port pins
  input wire logic [7:0] primary_pin_in,
  output logic [7:0] primary_pin_out,
  output logic [7:0] primary_pin_oe_n,
  // secondary port pins
  input wire logic input_only_pin,
  input wire logic [1:0] bidir_pin_in,
  output logic [1:0] bidir_pin_out,
  output logic [1:0] bidir_pin_oe_n,
  // drives from on-chip peripherals
  input wire logic uart_rx_drive,
  input wire logic uart_tx_drive,
  input wire logic pwm_drive,
  input wire logic spi_sck_drive,
  input wire logic spi_mosi_drive,
  // levels to on-chip peripherals
  output logic uart_rx_in,
  output logic ext_interrupt_a_n,
  output logic ext_interrupt_b_n,
  output logic timer_a_count_input,
  output logic timer_b_count_input,
  output logic timer_c_count_input,
  output logic serial_master_in,
  output logic spi_to_radio
);
  gam_cfg_if cfg ();
  logic [7:0] prim_sync;
  logic [2:0] sec_sync;
  logic [7:0] next_prim_drive;
  logic [7:0] next_prim_val;
  logic [1:0] next_sec_drive;
  logic [1:0] next_sec_val;
  logic [7:0] next_rdata;
  logic spi_on;

  // drive enable and value of one primary pin
  function automatic logic [1:0] prim_function(
    input logic [2:0] idx,
    input logic alt,
    input logic dir,
    input logic data,
    input logic rx,
    input logic tx,
    input logic pwm
  );
    logic drive;
    logic val;
    drive = !dir;
    val = data;
    if (alt && idx != 3'(gam_pkg::BIT_BOOT_SELECT))
    begin
      case (idx)
        // receive pin keeps its direction bit
        3'(gam_pkg::BIT_UART_RX):
        begin
          drive = !dir;
          val = rx;
        end
        3'(gam_pkg::BIT_UART_TX):
        begin
          drive = 1'b1;
          val = tx;
        end
        3'(gam_pkg::BIT_PWM):
        begin
          drive = 1'b1;
          val = pwm;
        end
        default:
        begin
          drive = 1'b0;
          val = 1'b0;
        end
      endcase
    end
    return {drive, val};
  endfunction : prim_function

  gam_sfr_file u_sfr_file (
    .mclk(mclk),
    .rst_n(rst_n),
    .sfr_wr(sfr_wr),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .cfg(cfg.owner)
  );

  // eleven pins, input-only pin on top
  gam_sync #(
    .WIDTH(gam_pkg::PRIM_W + gam_pkg::SEC_W)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({input_only_pin, bidir_pin_in, primary_pin_in}),
    .sync_out({sec_sync, prim_sync})
  );

  // bit i drives primary pin i
  always_comb
  begin
    next_prim_drive = '0;
    next_prim_val = '0;
    for (int i = 0; i < gam_pkg::PRIM_W; i++)
    begin
      {next_prim_drive[i], next_prim_val[i]} = prim_function(3'(i), cfg.prim_alt[i], cfg.prim_dir[i],
        cfg.prim_data[i], uart_rx_drive, uart_tx_drive, pwm_drive);
    end
  end

  always_comb
  begin
    spi_on = cfg.spi_route == gam_pkg::ROUTE_PINS;
    if (spi_on)
    begin
      next_sec_drive = 2'h3;
      next_sec_val = {spi_mosi_drive, spi_sck_drive};
    end
    else
    begin
      next_sec_drive[0] = !cfg.sec_alt[gam_pkg::BIT_SEC_CLOCK] && !cfg.sec_dir[gam_pkg::BIT_SEC_CLOCK];
      next_sec_drive[1] = !cfg.sec_dir[gam_pkg::BIT_SEC_DATA_OUT];
      next_sec_val = cfg.sec_data[1:0];
    end
  end

  // drivers off while reset is held
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      primary_pin_oe_n <= '1;
      primary_pin_out <= '0;
      bidir_pin_oe_n <= '1;
      bidir_pin_out <= '0;
    end
    else
    begin
      primary_pin_oe_n <= ~next_prim_drive;
      primary_pin_out <= next_prim_val;
      bidir_pin_oe_n <= ~next_sec_drive;
      bidir_pin_out <= next_sec_val;
    end
  end

  // interrupt and uart receive levels gated by alternate bits
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ext_interrupt_a_n <= 1'b1;
      ext_interrupt_b_n <= 1'b1;
      uart_rx_in <= 1'b1;
    end
    else
    begin
      ext_interrupt_a_n <= cfg.prim_alt[gam_pkg::BIT_INT_A] ? prim_sync[gam_pkg::BIT_INT_A] : 1'b1;
      ext_interrupt_b_n <= cfg.prim_alt[gam_pkg::BIT_INT_B] ? prim_sync[gam_pkg::BIT_INT_B] : 1'b1;
      uart_rx_in <= cfg.prim_alt[gam_pkg::BIT_UART_RX] ? prim_sync[gam_pkg::BIT_UART_RX] : 1'b1;
    end
  end

  // timer count inputs and spi receive line
  // radio routing leaves pins alone
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      timer_a_count_input <= 1'b0;
      timer_b_count_input <= 1'b0;
      timer_c_count_input <= 1'b0;
      serial_master_in <= 1'b0;
      spi_to_radio <= 1'b0;
    end
    else
    begin
      timer_a_count_input <= cfg.prim_alt[gam_pkg::BIT_TIMER_A] && prim_sync[gam_pkg::BIT_TIMER_A];
      timer_b_count_input <= cfg.prim_alt[gam_pkg::BIT_TIMER_B] && prim_sync[gam_pkg::BIT_TIMER_B];
      timer_c_count_input <= !spi_on && cfg.sec_alt[gam_pkg::BIT_SEC_CLOCK] && sec_sync[gam_pkg::BIT_SEC_CLOCK];
      serial_master_in <= spi_on && sec_sync[gam_pkg::BIT_SEC_DATA_IN];
      spi_to_radio <= cfg.spi_route[1];
    end
  end

  // undriven bits read the pin level
  always_comb
  begin
    case (sfr_addr)
      gam_pkg::OFS_PRIMARY_PORT_DATA:
        next_rdata = (prim_sync & primary_pin_oe_n) | (cfg.prim_data & ~primary_pin_oe_n);
      gam_pkg::OFS_PRIMARY_PORT_DIRECTION: next_rdata = cfg.prim_dir;
      gam_pkg::OFS_PRIMARY_PORT_ALT_SELECT: next_rdata = cfg.prim_alt;
      gam_pkg::OFS_SECONDARY_PORT_DATA:
        next_rdata = {5'h00, sec_sync[2], (sec_sync[1:0] & bidir_pin_oe_n) | (cfg.sec_data[1:0] & ~bidir_pin_oe_n)};
      gam_pkg::OFS_SECONDARY_PORT_DIRECTION: next_rdata = {5'h00, cfg.sec_dir};
      gam_pkg::OFS_SECONDARY_PORT_ALT_SELECT: next_rdata = {5'h00, cfg.sec_alt};
      gam_pkg::OFS_SPI_ROUTE: next_rdata = {6'h00, cfg.spi_route};
      default: next_rdata = gam_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sfr_rdata <= 8'h00;
    end
    else if (sfr_rd)
    begin
      sfr_rdata <= next_rdata;
    end
  end

  chk_reset_all_inputs: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(!rst_n) |-> (primary_pin_oe_n == 8'hFF && bidir_pin_oe_n == 2'h3))
    else $error("pin driven straight after reset");

  chk_gpio_output_drive: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(!cfg.prim_alt[5] && !cfg.prim_dir[5]) |-> (!primary_pin_oe_n[5] && primary_pin_out[5] == $past(cfg.prim_data[5])))
    else $error("general purpose output not driving latch");

  chk_gpio_input_dir: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(!cfg.prim_alt[6] && cfg.prim_dir[6]) |-> primary_pin_oe_n[6])
    else $error("general purpose input is driven");

  chk_alt_beats_dir: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(cfg.prim_alt[4]) |-> primary_pin_oe_n[4])
    else $error("interrupt pin driven with alternate set");

  chk_rx_follows_dir: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(cfg.prim_alt[1]) |-> (primary_pin_oe_n[1] == $past(cfg.prim_dir[1])))
    else $error("receive pin direction wrong");

  chk_boot_bit_gpio: assert property (@(posedge mclk) disable iff (!rst_n)
    (primary_pin_oe_n[0] == $past(cfg.prim_dir[0])) && (!primary_pin_oe_n[0] -> primary_pin_out[0] == $past(cfg.prim_data[0])))
    else $error("boot select bit not general purpose");

  chk_pwm_routed: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(cfg.prim_alt[7]) |-> (!primary_pin_oe_n[7] && primary_pin_out[7] == $past(pwm_drive)))
    else $error("pwm not on top primary pin");

  chk_int_gated: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg.prim_alt[3] [*2]) |-> ext_interrupt_a_n)
    else $error("interrupt passed without alternate select");

  chk_spi_clock_pin: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(cfg.spi_route == 2'h1) |-> (bidir_pin_oe_n == 2'h0 && bidir_pin_out[0] == $past(spi_sck_drive)))
    else $error("spi clock not on secondary pin");

  chk_int_b_gated: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg.prim_alt[4] [*2]) |-> ext_interrupt_b_n)
    else $error("second interrupt passed without alternate select");

  chk_tx_routed: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(cfg.prim_alt[2]) |-> (!primary_pin_oe_n[2] && primary_pin_out[2] == $past(uart_tx_drive)))
    else $error("transmit not driven on its pin");

  chk_timer_gated: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(!cfg.prim_alt[5]) |-> !timer_a_count_input)
    else $error("timer count passed without alternate select");

  chk_sec_data_dir: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(cfg.spi_route != 2'h1) |-> (bidir_pin_oe_n[1] == $past(cfg.sec_dir[1])))
    else $error("secondary data pin ignores its direction");

  chk_radio_route: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(cfg.spi_route[1]) |-> (spi_to_radio && !serial_master_in))
    else $error("radio route still uses the pins");

  chk_dir_readback: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(sfr_rd && sfr_addr == gam_pkg::OFS_PRIMARY_PORT_DIRECTION) |-> (sfr_rdata == $past(cfg.prim_dir)))
    else $error("direction register read back wrong");
endmodule : gam_pin_mux
`default_nettype wire

// ### hdl/gam_pkg.sv
// constants for the pin multiplexer block
`default_nettype none
package gam_pkg;
  // register offsets on the special function register port
  localparam logic [7:0] OFS_PRIMARY_PORT_DATA = 8'h80;
  localparam logic [7:0] OFS_PRIMARY_PORT_DIRECTION = 8'h94;
  localparam logic [7:0] OFS_PRIMARY_PORT_ALT_SELECT = 8'h95;
  localparam logic [7:0] OFS_SECONDARY_PORT_DATA = 8'h90;
  localparam logic [7:0] OFS_SECONDARY_PORT_DIRECTION = 8'h96;
  localparam logic [7:0] OFS_SECONDARY_PORT_ALT_SELECT = 8'h97;
  localparam logic [7:0] OFS_SPI_ROUTE = 8'hB3;
  // widths
  localparam int PRIM_W = 8;
  localparam int SEC_W = 3;
  localparam int ROUTE_W = 2;
  // reset values
  localparam logic [7:0] RST_PRIMARY_DATA = 8'hFF;
  localparam logic [7:0] RST_PRIMARY_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_PRIMARY_ALT = 8'h00;
  localparam logic [2:0] RST_SECONDARY_DATA = 3'h7;
  localparam logic [2:0] RST_SECONDARY_DIRECTION = 3'h7;
  localparam logic [2:0] RST_SECONDARY_ALT = 3'h0;
  localparam logic [1:0] RST_SPI_ROUTE = 2'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // spi routing codes
  localparam logic [1:0] ROUTE_PINS = 2'h1;
  // field positions in the primary port
  localparam int BIT_BOOT_SELECT = 0;
  localparam int BIT_UART_RX = 1;
  localparam int BIT_UART_TX = 2;
  localparam int BIT_INT_A = 3;
  localparam int BIT_INT_B = 4;
  localparam int BIT_TIMER_A = 5;
  localparam int BIT_TIMER_B = 6;
  localparam int BIT_PWM = 7;
  // field positions in the secondary port
  localparam int BIT_SEC_CLOCK = 0;
  localparam int BIT_SEC_DATA_OUT = 1;
  localparam int BIT_SEC_DATA_IN = 2;
  // pin synchroniser depth
  localparam int SYNC_STAGES = 2;
endpackage : gam_pkg
`default_nettype wire

// ### hdl/gam_cfg_if.sv
// configuration registers passed from the register file to the mux
`timescale 1ns/10ps
`default_nettype none
interface gam_cfg_if;
  logic [7:0] prim_data;
  logic [7:0] prim_dir;
  logic [7:0] prim_alt;
  logic [2:0] sec_data;
  logic [2:0] sec_dir;
  logic [2:0] sec_alt;
  logic [1:0] spi_route;
  modport owner (output prim_data, prim_dir, prim_alt, sec_data, sec_dir, sec_alt, spi_route);
  modport user (input prim_data, prim_dir, prim_alt, sec_data, sec_dir, sec_alt, spi_route);
endinterface : gam_cfg_if
`default_nettype wire

// ### hdl/gam_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module gam_sync #(
  parameter int WIDTH = 11
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pins and synchronised levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      stage_one <= '1;
      sync_out <= '1;
    end
    else
    begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule : gam_sync
`default_nettype wire

// ### hdl/gam_sfr_file.sv
// port configuration registers written over the register port
`timescale 1ns/10ps
`default_nettype none
module gam_sfr_file (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register write port
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  // register contents
  gam_cfg_if.owner cfg
);
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cfg.prim_data <= gam_pkg::RST_PRIMARY_DATA;
      cfg.prim_dir <= gam_pkg::RST_PRIMARY_DIRECTION;
      cfg.prim_alt <= gam_pkg::RST_PRIMARY_ALT;
      cfg.sec_data <= gam_pkg::RST_SECONDARY_DATA;
      cfg.sec_dir <= gam_pkg::RST_SECONDARY_DIRECTION;
      cfg.sec_alt <= gam_pkg::RST_SECONDARY_ALT;
      cfg.spi_route <= gam_pkg::RST_SPI_ROUTE;
    end
    else if (sfr_wr)
    begin
      case (sfr_addr)
        gam_pkg::OFS_PRIMARY_PORT_DATA: cfg.prim_data <= sfr_wdata;
        gam_pkg::OFS_PRIMARY_PORT_DIRECTION: cfg.prim_dir <= sfr_wdata;
        gam_pkg::OFS_PRIMARY_PORT_ALT_SELECT: cfg.prim_alt <= sfr_wdata;
        gam_pkg::OFS_SECONDARY_PORT_DATA: cfg.sec_data <= sfr_wdata[2:0];
        gam_pkg::OFS_SECONDARY_PORT_DIRECTION: cfg.sec_dir <= sfr_wdata[2:0];
        gam_pkg::OFS_SECONDARY_PORT_ALT_SELECT: cfg.sec_alt <= sfr_wdata[2:0];
        gam_pkg::OFS_SPI_ROUTE: cfg.spi_route <= sfr_wdata[1:0];
        default: ;
      endcase
    end
  end

  chk_reset_values: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(!rst_n) |-> (cfg.prim_data == 8'hFF && cfg.prim_dir == 8'hFF && cfg.prim_alt == 8'h00))
    else $error("port registers not at reset values");
endmodule : gam_sfr_file
`default_nettype wire

// ### hdl/gam_top_unused_placeholder_none.sv
// intentionally empty compilation unit
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ### test/gam_pin_model.sv
// far-side pin drivers with wire resolution for the pin multiplexer
`timescale 1ns/10ps
`default_nettype none
module gam_pin_model (
  // device side of the pins
  input wire logic [7:0] prim_out,
  input wire logic [7:0] prim_oe_n,
  input wire logic [1:0] sec_out,
  input wire logic [1:0] sec_oe_n,
  // levels the outside world drives
  input wire logic [7:0] ext_prim,
  input wire logic [1:0] ext_sec,
  input wire logic ext_din,
  // resolved pin levels
  output logic [7:0] prim_pin,
  output logic [1:0] sec_pin,
  output logic din_pin
);
  // pin i carries data bit i
  assign prim_pin = (prim_oe_n & ext_prim) | (~prim_oe_n & prim_out);
  // two two-way pins, one input only
  assign sec_pin = (sec_oe_n & ext_sec) | (~sec_oe_n & sec_out);
  assign din_pin = ext_din;
endmodule : gam_pin_model
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the pin multiplexer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [7:0] p_in, p_out, p_oe_n, ext_prim;
  logic [1:0] s_in, s_out, s_oe_n, ext_sec;
  logic din, ext_din;
  logic rx_d = 1'b1;
  logic tx_d = 1'b1;
  logic pwm_d = 1'b0;
  logic sck_d = 1'b1;
  logic mosi_d = 1'b0;
  logic rx_in, ia_n, ib_n, ta, tb, tc, smi, radio;
  int err_count = 0;
  int samples_checked = 0;

  always #2 mclk = ~mclk;

  gam_pin_mux i_dut (
    .mclk(mclk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .primary_pin_in(p_in), .primary_pin_out(p_out), .primary_pin_oe_n(p_oe_n),
    .input_only_pin(din), .bidir_pin_in(s_in), .bidir_pin_out(s_out), .bidir_pin_oe_n(s_oe_n),
    .uart_rx_drive(rx_d), .uart_tx_drive(tx_d), .pwm_drive(pwm_d),
    .spi_sck_drive(sck_d), .spi_mosi_drive(mosi_d),
    .uart_rx_in(rx_in), .ext_interrupt_a_n(ia_n), .ext_interrupt_b_n(ib_n),
    .timer_a_count_input(ta), .timer_b_count_input(tb), .timer_c_count_input(tc),
    .serial_master_in(smi), .spi_to_radio(radio)
  );

  gam_pin_model i_far (
    .prim_out(p_out), .prim_oe_n(p_oe_n), .sec_out(s_out), .sec_oe_n(s_oe_n),
    .ext_prim(ext_prim), .ext_sec(ext_sec), .ext_din(ext_din),
    .prim_pin(p_in), .sec_pin(s_in), .din_pin(din)
  );

  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge mclk);
    #1;
    sfr_wr = 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp, input string n);
    @(posedge mclk);
    #1;
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge mclk);
    #1;
    sfr_rd = 1'b0;
    chk(n, sfr_rdata, exp);
  endtask : rd

  // covers register and pin sync latency
  task settle;
    repeat (4) @(posedge mclk);
    #1;
  endtask : settle

  task end_of_test;
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    #8000;
    err_count++;
    end_of_test();
  end

  initial
  begin
    ext_prim = 8'hA5;
    ext_sec = 2'h0;
    ext_din = 1'b0;
    repeat (12) @(posedge mclk);
    #1;
    chk("oe_in_reset", p_oe_n, 8'hFF);
    chk("sec_oe_in_reset", {6'h00, s_oe_n}, 8'h03);
    rst_n = 1'b1;
    rd(gam_pkg::OFS_PRIMARY_PORT_DIRECTION, 8'hFF, "dir_reset");
    rd(gam_pkg::OFS_PRIMARY_PORT_ALT_SELECT, 8'h00, "alt_reset");
    rd(gam_pkg::OFS_PRIMARY_PORT_DATA, 8'hA5, "data_pin_level");
    rd(8'h81, gam_pkg::UNMAPPED_READ, "unmapped");
    chk("oe_after_reset", p_oe_n, 8'hFF);
    wr(gam_pkg::OFS_PRIMARY_PORT_DATA, 8'h3C);
    wr(gam_pkg::OFS_PRIMARY_PORT_DIRECTION, 8'h00);
    settle();
    chk("gpio_oe", p_oe_n, 8'h00);
    chk("gpio_out", p_out, 8'h3C);
    rd(gam_pkg::OFS_PRIMARY_PORT_DATA, 8'h3C, "data_latch");
    wr(gam_pkg::OFS_PRIMARY_PORT_ALT_SELECT, 8'hFF);
    settle();
    chk("alt_oe_dir0", p_oe_n, 8'h78);
    chk("alt_out_dir0", p_out & ~p_oe_n, 8'h06);
    pwm_d = 1'b1;
    settle();
    chk("pwm_out", p_out & 8'h87, 8'h86);
    ext_prim = 8'h00;
    wr(gam_pkg::OFS_PRIMARY_PORT_DIRECTION, 8'hFF);
    settle();
    chk("alt_oe_dir1", p_oe_n, 8'h7B);
    chk("periph_low", {3'h0, rx_in, ia_n, ib_n, ta, tb}, 8'h00);
    ext_prim = 8'hFF;
    settle();
    chk("periph_high", {3'h0, rx_in, ia_n, ib_n, ta, tb}, 8'h1F);
    ext_prim = 8'h00;
    wr(gam_pkg::OFS_PRIMARY_PORT_ALT_SELECT, 8'h00);
    settle();
    chk("periph_gated", {3'h0, rx_in, ia_n, ib_n, ta, tb}, 8'h1C);
    wr(gam_pkg::OFS_SECONDARY_PORT_DATA, 8'h02);
    wr(gam_pkg::OFS_SECONDARY_PORT_DIRECTION, 8'h00);
    settle();
    chk("sec_gpio", {4'h0, s_oe_n, s_out}, 8'h02);
    ext_din = 1'b1;
    wr(gam_pkg::OFS_SPI_ROUTE, 8'h01);
    settle();
    chk("spi_pins", {4'h0, s_oe_n, s_out}, 8'h01);
    chk("spi_data_in", {7'h00, smi}, 8'h01);
    ext_sec = 2'h1;
    wr(gam_pkg::OFS_SECONDARY_PORT_DIRECTION, 8'h07);
    wr(gam_pkg::OFS_SECONDARY_PORT_ALT_SELECT, 8'h01);
    wr(gam_pkg::OFS_SPI_ROUTE, 8'h00);
    settle();
    chk("timer_c", {5'h00, s_oe_n, tc}, 8'h07);
    wr(gam_pkg::OFS_SPI_ROUTE, 8'h02);
    settle();
    chk("radio_route", {6'h00, radio, smi}, 8'h02);
    rd(gam_pkg::OFS_SPI_ROUTE, 8'h02, "route_readback");
    rd(gam_pkg::OFS_SECONDARY_PORT_DATA, 8'h05, "sec_pin_level");
    wr(gam_pkg::OFS_PRIMARY_PORT_DIRECTION, 8'h00);
    settle();
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("oe_mid_reset", p_oe_n, 8'hFF);
    rst_n = 1'b1;
    rd(gam_pkg::OFS_PRIMARY_PORT_DIRECTION, 8'hFF, "dir_after_rerun");
    chk("oe_after_rerun", p_oe_n, 8'hFF);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
